// ### verification/lin_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module lin_far_model (
  // controller side
  input wire logic txWant,
  output logic linTransmitInput,
  // bus side
  input wire logic nodeDom,
  input wire logic busDriveDominant,
  output logic busSense
);
  // pin rests high unless a dominant bit is asked for
  assign linTransmitInput = ~txWant;
  // pulled-up wire: low when any node drives dominant
  assign busSense = ~(busDriveDominant | nodeDom);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) n_tests++; if ((g) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", nm, e, g); end
module tb_top
  import lin_mode_pkg::*;
;
  logic core_clk = 0, arst_n = 0, modeWrite = 0, faultClear = 0, txWant = 0, nodeDom = 0;
  logic [1:0] modeWdata = 2'h0;
  chip_mode_type chipMode = CHIP_NORMAL;
  logic linTransmitInput, busSense, rxdOut, busDriveDominant, wakeEvent, linFaultFlag;
  logic [1:0] linModeField;
  int failures = 0, n_tests = 0, wakes = 0, w;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (wakeEvent === 1'b1) wakes++;
  lin_transceiver_mode_control dut_u (.core_clk(core_clk), .arst_n(arst_n),
    .modeWrite(modeWrite), .modeWdata(modeWdata), .linModeField(linModeField),
    .chipMode(chipMode), .linTransmitInput(linTransmitInput), .rxdOut(rxdOut),
    .busSense(busSense), .busDriveDominant(busDriveDominant), .wakeEvent(wakeEvent),
    .linFaultFlag(linFaultFlag), .faultClear(faultClear));
  lin_far_model far_u (.txWant(txWant), .linTransmitInput(linTransmitInput),
    .nodeDom(nodeDom), .busDriveDominant(busDriveDominant), .busSense(busSense));
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task wr(input logic [1:0] m);
    modeWrite = 1'b1;
    modeWdata = m;
    cyc(1);
    modeWrite = 1'b0;
    cyc(1);
  endtask
  task complete_run;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task offMode;
    `CHK("mode", 2'h0, linModeField)
    nodeDom = 1'b1;
    cyc(WAKE_CYCLES + 100);
    nodeDom = 1'b0;
    cyc(10);
    `CHK("wakes", 0, wakes)
    `CHK("rxd", 1'b1, rxdOut)
    `CHK("drive", 1'b0, busDriveDominant)
  endtask
  task refused;
    chipMode = CHIP_SLEEP;
    wr(MODE_NORMAL);
    `CHK("mode", 2'h0, linModeField)
    wr(MODE_RXONLY);
    `CHK("mode", 2'h0, linModeField)
    chipMode = CHIP_STOP;
    wr(MODE_RXONLY);
    `CHK("mode", MODE_RXONLY, linModeField)
    chipMode = CHIP_SLEEP;
    cyc(2);
    `CHK("mode", MODE_WAKE, linModeField)
    chipMode = CHIP_RESTART;
    wr(MODE_OFF);
    chipMode = CHIP_FAILSAFE;
    cyc(2);
    `CHK("mode", 2'h1, linModeField)
    chipMode = CHIP_NORMAL;
    wr(MODE_OFF);
    `CHK("mode", MODE_OFF, linModeField)
  endtask
  task normalMode;
    txWant = 1'b1;
    wr(MODE_NORMAL);
    `CHK("mode", MODE_NORMAL, linModeField)
    cyc(EN_CYCLES + 20);
    `CHK("drive", 1'b0, busDriveDominant)
    txWant = 1'b0;
    cyc(5);
    txWant = 1'b1;
    cyc(4);
    `CHK("drive", 1'b1, busDriveDominant)
    cyc(4);
    `CHK("rxd", 1'b0, rxdOut)
    txWant = 1'b0;
    cyc(4);
    `CHK("drive", 1'b0, busDriveDominant)
    cyc(4);
    `CHK("rxd", 1'b1, rxdOut)
  endtask
  task timeoutCase;
    txWant = 1'b1;
    cyc(TXTO_CYCLES + 10);
    `CHK("drive", 1'b0, busDriveDominant)
    `CHK("fault", 1'b1, linFaultFlag)
    txWant = 1'b0;
    cyc(5);
    faultClear = 1'b1;
    cyc(1);
    faultClear = 1'b0;
    cyc(2);
    `CHK("fault", 1'b0, linFaultFlag)
    `CHK("mode", MODE_NORMAL, linModeField)
    txWant = 1'b1;
    cyc(4);
    `CHK("drive", 1'b1, busDriveDominant)
    txWant = 1'b0;
    cyc(4);
  endtask
  task rxOnly;
    wr(MODE_RXONLY);
    `CHK("mode", MODE_RXONLY, linModeField)
    txWant = 1'b1;
    nodeDom = 1'b1;
    cyc(8);
    `CHK("drive", 1'b0, busDriveDominant)
    `CHK("rxd", 1'b0, rxdOut)
    txWant = 1'b0;
    nodeDom = 1'b0;
    cyc(8);
    `CHK("rxd", 1'b1, rxdOut)
  endtask
  task wakeCase;
    wr(MODE_WAKE);
    `CHK("mode", 2'h1, linModeField)
    txWant = 1'b1;
    nodeDom = 1'b1;
    cyc(WAKE_CYCLES + 20);
    `CHK("drive", 1'b0, busDriveDominant)
    nodeDom = 1'b0;
    w = wakes;
    cyc(10);
    `CHK("wakes", w + 1, wakes)
    `CHK("rxd", 1'b0, rxdOut)
    `CHK("mode", 2'h1, linModeField)
    txWant = 1'b0;
    wr(MODE_OFF);
    cyc(4);
    `CHK("rxd", 1'b1, rxdOut)
  endtask
  initial begin
    cyc(6);
    arst_n = 1'b1;
    cyc(1);
    offMode();
    refused();
    normalMode();
    timeoutCase();
    rxOnly();
    wakeCase();
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/lin_mode_pkg.sv
package lin_mode_pkg;

  // transceiver mode field encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_WAKE = 2'h1;
  localparam logic [1:0] MODE_RXONLY = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_OFF;

  // chip operating modes
  typedef enum logic [2:0] {
    CHIP_NORMAL,
    CHIP_STOP,
    CHIP_SLEEP,
    CHIP_RESTART,
    CHIP_FAILSAFE
  } chip_mode_type;

  localparam int CLK_HZ = 10000000;
  // enable time in microseconds
  localparam int EN_TIME_US = 18;
  localparam int EN_CYCLES = (EN_TIME_US * (CLK_HZ / 1000000));
  // transmit dominant time-out in microseconds
  localparam int TXTO_TIME_US = 6000;
  localparam int TXTO_CYCLES = (TXTO_TIME_US * (CLK_HZ / 1000000));
  // wake filter dominant time in microseconds
  localparam int WAKE_TIME_US = 150;
  localparam int WAKE_CYCLES = (WAKE_TIME_US * (CLK_HZ / 1000000));
  localparam int CNT_W = 20;

endpackage

// ### verilog/lin_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module lin_sync2 (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pin in, synchronised copy out
  input wire logic pinIn,
  output logic syncOut
);
  logic stage1_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= 1'b1;
      syncOut <= 1'b1;
    end else begin
      stage1_q <= pinIn;
      syncOut <= stage1_q;
    end
  end
endmodule
`default_nettype wire

// ### verilog/lin_timer.sv
`timescale 1ns/100ps
`default_nettype none
module lin_timer
  import lin_mode_pkg::*;
#(
  parameter logic [CNT_W-1:0] LIMIT = 20'h1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // count control
  input wire logic run,
  output logic expired
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  assign cnt_d = !run ? '0 : (cnt_q == LIMIT) ? cnt_q : cnt_q + 20'h1;
  assign expired = run && (cnt_q == LIMIT);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/lin_transceiver_mode_control.sv
// Function
// - mode chosen from written mode field
// - off mode after power-up
// - off allowed always; no transmit or receive
// - off mode ignores bus wake
// - normal mode entered on request in normal
// - normal only in chip normal or stop
// - normal: transmit low drives bus dominant
// - only dominant begun after enable transmits
// - normal: receive output follows bus level
// - receive-only: driver off, receive tracks bus
// - receive-only only in chip normal or stop
// - wake field reads 01 after wake
// - after wake receive held low
// - transmit time-out disables driver, sets fault
`timescale 1ns/100ps
`default_nettype none
module lin_transceiver_mode_control
  import lin_mode_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // mode field write port
  input wire logic modeWrite,
  input wire logic [1:0] modeWdata,
  output logic [1:0] linModeField,
  input wire chip_mode_type chipMode,
  // controller pins
  input wire logic linTransmitInput,
  output logic rxdOut,
  // bus pin and driver
  input wire logic busSense,
  output logic busDriveDominant,
  // status
  output logic wakeEvent,
  output logic linFaultFlag,
  input wire logic faultClear
);
  logic txdSync;
  logic busSync;
  logic [1:0] mode_q;
  logic [1:0] mode_d;
  logic woken_q;
  logic woken_d;
  logic armed_q;
  logic enDone_q;
  logic gate_q;
  logic gate_d;
  logic fault_q;
  logic wakeEv_q;
  logic rxd_q;
  logic drive_q;
  logic prevBus_q;
  logic wakeLong_q;
  logic enExpired;
  logic txToExpired;
  logic wakeExpired;
  logic chipActive;
  logic wrLegal;
  logic isNormal;
  logic modeChange;
  logic busRise;
  logic wakeDetect;
  logic driveNext;
  logic rearmChip;
  logic armed_d;
  logic enDone_d;
  logic fault_d;
  logic wakeLong_d;
  logic rxTrack;
  logic rxHoldLow;
  logic rxd_d;

  lin_sync2 u_sync_txd (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn(linTransmitInput),
    .syncOut(txdSync)
  );
  lin_sync2 u_sync_bus (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinIn(busSense),
    .syncOut(busSync)
  );

  // enable time counted from entry to normal
  lin_timer #(.LIMIT(CNT_W'(EN_CYCLES))) u_en_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run(isNormal),
    .expired(enExpired)
  );
  // transmit dominant time-out
  lin_timer #(.LIMIT(CNT_W'(TXTO_CYCLES))) u_txto_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run(isNormal && !txdSync),
    .expired(txToExpired)
  );
  // wake filter on dominant bus
  lin_timer #(.LIMIT(CNT_W'(WAKE_CYCLES))) u_wake_timer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .run((mode_q == MODE_WAKE) && !busSync),
    .expired(wakeExpired)
  );

  assign chipActive = (chipMode == CHIP_NORMAL) || (chipMode == CHIP_STOP);
  // off and wake always legal; normal/rx-only need normal or stop
  assign wrLegal = (modeWdata == MODE_OFF) || (modeWdata == MODE_WAKE) || chipActive;
  assign isNormal = (mode_q == MODE_NORMAL);

  always_comb begin
    mode_d = mode_q;
    if (modeWrite && wrLegal) begin
      mode_d = modeWdata;
    end else if (chipMode == CHIP_FAILSAFE) begin
      mode_d = MODE_WAKE;
    end else if (!chipActive && (mode_q == MODE_NORMAL || mode_q == MODE_RXONLY)) begin
      mode_d = MODE_WAKE;
    end
  end
  assign modeChange = (mode_d != mode_q);
  assign linModeField = mode_q;

  // wake: dominant longer than filter, then release
  assign busRise = busSync && !prevBus_q;
  assign rearmChip = (chipMode == CHIP_STOP) || (chipMode == CHIP_SLEEP)
    || (chipMode == CHIP_FAILSAFE);
  assign wakeDetect = (mode_q == MODE_WAKE) && armed_q && wakeLong_q && busRise;
  assign woken_d = modeChange ? 1'b0 : (woken_q || wakeDetect);

  // gate opens only on recessive transmit after enable
  assign gate_d = !isNormal || modeChange ? 1'b0 : (gate_q || (enDone_q && txdSync));
  assign driveNext = isNormal && !modeChange && gate_q && !txdSync && !txToExpired;

  // next values of the state flags
  assign armed_d = ((modeChange && mode_q == MODE_WAKE) || rearmChip) ? 1'b1
    : (wakeDetect ? 1'b0 : armed_q);
  assign enDone_d = (isNormal && !modeChange) && (enDone_q || enExpired);
  // set wins over clear
  assign fault_d = (isNormal && txToExpired) || (fault_q && !faultClear);
  assign wakeLong_d = busSync ? 1'b0 : (wakeLong_q || wakeExpired);
  // receive follows bus when listening, low after wake, idle high otherwise
  assign rxTrack = (mode_d == MODE_NORMAL) || (mode_d == MODE_RXONLY);
  assign rxHoldLow = (mode_d == MODE_WAKE) && woken_d;
  assign rxd_d = rxTrack ? busSync : !rxHoldLow;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RESET;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      woken_q <= 1'b0;
    end else begin
      woken_q <= woken_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= armed_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enDone_q <= 1'b0;
    end else begin
      enDone_q <= enDone_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeEv_q <= 1'b0;
    end else begin
      wakeEv_q <= wakeDetect;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prevBus_q <= 1'b1;
    end else begin
      prevBus_q <= busSync;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeLong_q <= 1'b0;
    end else begin
      wakeLong_q <= wakeLong_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= driveNext;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd_d;
    end
  end

  assign busDriveDominant = drive_q;
  assign rxdOut = rxd_q;
  assign wakeEvent = wakeEv_q;
  assign linFaultFlag = fault_q;

  a_off_no_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_q == MODE_OFF) |=> !busDriveDominant || $past(mode_q) != MODE_OFF)
    else $error("driver active in off mode");
  a_nonnormal_recessive: assert property (@(posedge core_clk) disable iff (!arst_n)
    !isNormal |=> !busDriveDominant)
    else $error("driver active outside normal mode");
  a_off_no_wake: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_q == MODE_OFF) |=> !wakeEvent)
    else $error("wake reported in off mode");
  a_off_rxd_high: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_q == MODE_OFF) && $stable(mode_q) |-> rxdOut)
    else $error("receive active in off mode");
  a_normal_gated: assert property (@(posedge core_clk) disable iff (!arst_n)
    isNormal |-> chipActive || $past(chipActive))
    else $error("normal mode outside normal or stop");
  a_no_early_dom: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(isNormal) ##1 !txdSync [*3] |-> !busDriveDominant)
    else $error("early dominant reached bus");
  a_rxonly_tracks: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_q == MODE_RXONLY) && (mode_d == MODE_RXONLY) |=> !busDriveDominant
      && (rxdOut == $past(busSync)))
    else $error("receive-only not tracking");
  a_wake_rxd_low: assert property (@(posedge core_clk) disable iff (!arst_n)
    woken_q && (mode_q == MODE_WAKE) && (mode_d == MODE_WAKE) |=> !rxdOut)
    else $error("receive not held low after wake");
  a_txto_fault: assert property (@(posedge core_clk) disable iff (!arst_n)
    isNormal && txToExpired |=> linFaultFlag && !busDriveDominant)
    else $error("time-out not handled");
  a_wake_field: assert property (@(posedge core_clk) disable iff (!arst_n)
    wakeEvent |-> linModeField == MODE_WAKE || $past(modeWrite))
    else $error("field changed after wake");

  c_normal_tx: cover property (@(posedge core_clk) disable iff (!arst_n)
    isNormal && busDriveDominant);
  c_wake: cover property (@(posedge core_clk) disable iff (!arst_n) wakeEvent);
  a_normal_rxd: assert property (@(posedge core_clk) disable iff (!arst_n)
    isNormal && (mode_d == MODE_NORMAL) |=> rxdOut == $past(busSync))
    else $error("receive not following bus");
  a_gate_closed: assert property (@(posedge core_clk) disable iff (!arst_n)
    !gate_q |=> !busDriveDominant)
    else $error("dominant sent before gate opened");
  a_chip_inactive: assert property (@(posedge core_clk) disable iff (!arst_n)
    !chipActive |=> !isNormal && (linModeField != MODE_RXONLY))
    else $error("active mode kept outside normal or stop");
  a_off_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    modeWrite && (modeWdata == MODE_OFF) |=> linModeField == MODE_OFF)
    else $error("off mode write refused");
  a_normal_entry: assert property (@(posedge core_clk) disable iff (!arst_n)
    modeWrite && chipActive && (modeWdata == MODE_NORMAL) |=> isNormal)
    else $error("normal mode write not taken");
  a_fault_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    linFaultFlag && !faultClear |=> linFaultFlag)
    else $error("fault flag lost without clear");
  a_wake_source: assert property (@(posedge core_clk) disable iff (!arst_n)
    wakeEvent |-> $past(mode_q) == MODE_WAKE)
    else $error("wake reported outside wake mode");

  c_timeout: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(linFaultFlag));
  c_rx_only: cover property (@(posedge core_clk) disable iff (!arst_n)
    (mode_q == MODE_RXONLY) && !rxdOut);
  c_fault_clear: cover property (@(posedge core_clk) disable iff (!arst_n)
    $fell(linFaultFlag));
endmodule
`default_nettype wire
